// [verilog/rxs_defines.vh]
// Constants of the reset and exception start sequencer.
// Assumes inclusion by bare name from the design files.
`ifndef RXS_DEFINES_VH
`define RXS_DEFINES_VH

// ==========================================================
// Timing
`define RXS_CLK_PERIOD_NS   25
`define RXS_MIN_LOW_CYCLES  18
`define RXS_LOW_CNT_W       5

// ==========================================================
// Vector and flag layout
`define RXS_RESET_VEC_ADDR  16'h0000
`define RXS_RESET_VEC_ADDR1 16'h0001
`define RXS_MASK_BIT        7
`define RXS_FLAGS_RESET     8'h80

// ==========================================================
// Watchdog
`define RXS_WDOG_W          8
`define RXS_WDOG_MAX        8'hff

`endif

// [verilog/rxs_sync.v]
// Two-flop synchroniser for the asynchronous reset pin level.
// Assumes one system clock and the block's asynchronous reset.
`timescale 1ns/10ps

module rxs_sync (
	// Clock and reset
	input  wire clock,
	input  wire nrst,
	// Level
	input  wire din,
	output wire dout
);

	reg meta_q;
	reg sync_q;

	// ==========================================================
	// Synchroniser
	// The first stage resets low so a pin held low never leaks a false release.
	always @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
		end else begin
			meta_q <= din;
			sync_q <= meta_q;
		end
	end

	assign dout = sync_q;

endmodule // rxs_sync

// [verilog/rxs_sequencer.v]
// Reset and exception start sequencer: holds the core in reset, runs reset
// exception processing, fetches the reset vector and gates interrupt entry.
// Assumes a 40 MHz system clock and a core that reports instruction ends.
//
// Overview of operation
// - Reset outranks every other exception source.
// - Interrupts start only after current instruction ends.
// - Low init pin halts processing, enters reset.
// - Reset processing starts on pin rising edge after the minimum low time.
// - Initialise core, peripherals; set mask flag.
// - Load program counter from vector at 0000.
// - Watchdog counts up once run bit set.
// - Watchdog overflow with flag clear sets restart flag, enters reset.
// - Next overflow with flag set releases reset.
// - Mask interrupts until first instruction executes.
`timescale 1ns/10ps
`include "rxs_defines.vh"

module rxs_sequencer (
	// Clock and reset
	input  wire        clock,
	input  wire        nrst,
	// External pin
	input  wire        chip_init_pin_n,
	// Watchdog control
	input  wire        wdog_run_bit,
	input  wire        wdog_tick,
	// Program memory read for the vector
	output reg  [15:0] mem_addr,
	output reg         mem_rd,
	input  wire        mem_ack,
	input  wire [7:0]  mem_rdata,
	// Core control
	output reg         core_halt,
	output reg         periph_init,
	output reg  [15:0] pc_load_value,
	output reg         pc_load,
	output reg  [7:0]  condition_flags_reg,
	input  wire        mask_flag_clear,
	input  wire        insn_done,
	// Interrupt entry
	input  wire        irq_req,
	output wire        irq_accept,
	// Status
	output reg  [7:0]  wdog_up_counter,
	output reg         wdog_restart_flag,
	output reg         low_time_short
);

	localparam ST_RESET  = 3'd0;
	localparam ST_INIT   = 3'd1;
	localparam ST_VEC_HI = 3'd2;
	localparam ST_VEC_LO = 3'd3;
	localparam ST_FIRST  = 3'd4;
	localparam ST_RUN    = 3'd5;

	localparam [31:0] LOW_MIN = `RXS_MIN_LOW_CYCLES;

	// ==========================================================
	// Pin synchronisation
	wire pin_sync;

	rxs_sync u_sync (
		.clock (clock),
		.nrst  (nrst),
		.din   (chip_init_pin_n),
		.dout  (pin_sync)
	);

	reg                      pin_q;
	reg [`RXS_LOW_CNT_W-1:0] low_cnt_q;
	reg [2:0]                state_q;
	reg [7:0]                vec_hi_q;
	reg                      wdog_in_reset_q;
	reg                      in_exception_q;

	wire pin_rise  = pin_sync & ~pin_q;
	wire wdog_ovf  = wdog_run_bit & wdog_tick & (wdog_up_counter == `RXS_WDOG_MAX);
	wire in_reset  = ~pin_sync | wdog_in_reset_q;
	// An external release only counts after the pin was seen low long enough.
	wire long_low  = (low_cnt_q >= `RXS_MIN_LOW_CYCLES);

	always @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			pin_q          <= 1'b0;
			// Leaving the block reset counts as a full low time, so a pin already high still starts.
			low_cnt_q      <= LOW_MIN[`RXS_LOW_CNT_W-1:0];
			low_time_short <= 1'b0;
		end else begin
			pin_q <= pin_sync;
			if (!pin_sync) begin
				if (!long_low)
					low_cnt_q <= low_cnt_q + 1'b1;
			end else begin
				low_cnt_q <= {`RXS_LOW_CNT_W{1'b0}};
			end
			// Records a release that came before the minimum low time.
			if (pin_rise)
				low_time_short <= ~long_low;
		end
	end

	// ==========================================================
	// Watchdog
	always @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			wdog_up_counter   <= 8'h00;
			wdog_restart_flag <= 1'b0;
			wdog_in_reset_q   <= 1'b0;
		end else if (!pin_sync) begin
			// The pin reset also clears the watchdog.
			wdog_up_counter   <= 8'h00;
			wdog_restart_flag <= 1'b0;
			wdog_in_reset_q   <= 1'b0;
		end else if (wdog_run_bit && wdog_tick) begin
			wdog_up_counter <= wdog_up_counter + 1'b1;
			if (wdog_ovf) begin
				if (wdog_restart_flag) begin
					wdog_in_reset_q <= 1'b0;
				end else begin
					wdog_restart_flag <= 1'b1;
					wdog_in_reset_q   <= 1'b1;
				end
			end
		end
	end

	wire wdog_release = wdog_in_reset_q & wdog_ovf & wdog_restart_flag;

	// ==========================================================
	// Sequencer
	always @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			state_q             <= ST_RESET;
			core_halt           <= 1'b1;
			periph_init         <= 1'b1;
			mem_addr            <= 16'h0000;
			mem_rd              <= 1'b0;
			pc_load             <= 1'b0;
			pc_load_value       <= 16'h0000;
			vec_hi_q            <= 8'h00;
			condition_flags_reg <= `RXS_FLAGS_RESET;
			in_exception_q      <= 1'b0;
		end else if (in_reset && !wdog_release) begin
			// Everything stops at once, whatever the state.
			state_q             <= ST_RESET;
			core_halt           <= 1'b1;
			periph_init         <= 1'b1;
			mem_rd              <= 1'b0;
			pc_load             <= 1'b0;
			condition_flags_reg <= `RXS_FLAGS_RESET;
			in_exception_q      <= 1'b0;
		end else begin
			pc_load <= 1'b0;
			case (state_q)
				ST_RESET: begin
					// Reset is handled ahead of any pending interrupt.
					if ((pin_rise && long_low) || wdog_release) begin
						state_q        <= ST_INIT;
						in_exception_q <= 1'b1;
					end
				end
				ST_INIT: begin
					periph_init         <= 1'b0;
					condition_flags_reg <= `RXS_FLAGS_RESET;
					mem_addr            <= `RXS_RESET_VEC_ADDR;
					mem_rd              <= 1'b1;
					state_q             <= ST_VEC_HI;
				end
				ST_VEC_HI: begin
					if (mem_ack) begin
						vec_hi_q <= mem_rdata;
						mem_addr <= `RXS_RESET_VEC_ADDR1;
						state_q  <= ST_VEC_LO;
					end
				end
				ST_VEC_LO: begin
					if (mem_ack) begin
						mem_rd         <= 1'b0;
						pc_load_value  <= {vec_hi_q, mem_rdata};
						pc_load        <= 1'b1;
						core_halt      <= 1'b0;
						in_exception_q <= 1'b0;
						state_q        <= ST_FIRST;
					end
				end
				ST_FIRST: begin
					// Stays here until the first instruction retires.
					if (insn_done)
						state_q <= ST_RUN;
				end
				ST_RUN: begin
					if (mask_flag_clear)
						condition_flags_reg[`RXS_MASK_BIT] <= 1'b0;
				end
				default: begin
					state_q <= ST_RESET;
				end
			endcase
		end
	end

	// Accepted only at an instruction boundary, unmasked, past the first instruction.
	assign irq_accept = irq_req & insn_done & (state_q == ST_RUN) &
		~condition_flags_reg[`RXS_MASK_BIT] & ~in_exception_q & ~in_reset;

endmodule // rxs_sequencer

// [testbench/rxs_pin_driver.sv]
// Model of the external reset circuit on the pin.
// Assumes the bench pulses start at a falling edge.
`timescale 1ns/10ps
module rxs_pin_driver (
	input wire       clock,
	input wire       start,
	input wire [7:0] low_len,
	output reg       pin_n
);
	reg [7:0] cnt_q = 8'h14;
	initial pin_n = 1'b0;
	always @(negedge clock) begin
		cnt_q <= start ? low_len : cnt_q - (cnt_q != 8'h00);
		pin_n <= !(start || cnt_q > 8'h01);
	end
endmodule // rxs_pin_driver

// [testbench/rxs_sequencer_monitor.sv]
// Checker on the sequencer ports.
// Assumes one clock domain.
`timescale 1ns/10ps
module rxs_sequencer_monitor (
	input wire        clock,
	input wire        nrst,
	input wire        chip_init_pin_n,
	input wire [15:0] mem_addr,
	input wire        mem_rd,
	input wire        mem_ack,
	input wire [7:0]  mem_rdata,
	input wire        core_halt,
	input wire [15:0] pc_load_value,
	input wire        pc_load,
	input wire [7:0]  condition_flags_reg,
	input wire        irq_accept,
	input wire [7:0]  wdog_up_counter,
	input wire        wdog_restart_flag
);
	default clocking @(posedge clock); endclocking
	default disable iff (!nrst);
	AST_HALT: assert property (!chip_init_pin_n [*4] |-> core_halt) else $error("no halt");
	AST_ADDR: assert property (mem_rd |-> mem_addr[15:1] == 15'h0000) else $error("bad addr");
	AST_HOLD: assert property (mem_rd && !mem_ack && chip_init_pin_n |=> mem_rd) else $error("read drop");
	AST_PULSE: assert property (pc_load |=> !pc_load) else $error("long load");
	AST_LOW: assert property (pc_load |-> $past(mem_ack) && $past(mem_addr) == 16'h0001
		&& pc_load_value[7:0] == $past(mem_rdata)) else $error("bad low byte");
	AST_MASK: assert property (core_halt |-> condition_flags_reg[7]) else $error("mask clear");
	AST_IRQM: assert property (condition_flags_reg[7] |-> !irq_accept) else $error("irq masked");
	AST_IRQH: assert property (core_halt |-> !irq_accept) else $error("irq in reset");
	AST_WDOG: assert property ($rose(wdog_restart_flag) |-> $past(wdog_up_counter) == 8'hff
		##[0:3] core_halt) else $error("wdog");
	cover property (pc_load);
	cover property (irq_accept);
	cover property ($rose(wdog_restart_flag));
endmodule // rxs_sequencer_monitor
bind rxs_sequencer rxs_sequencer_monitor u_mon (.clock(clock), .nrst(nrst), .chip_init_pin_n(chip_init_pin_n),
	.mem_addr(mem_addr), .mem_rd(mem_rd), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .core_halt(core_halt),
	.pc_load_value(pc_load_value), .pc_load(pc_load), .condition_flags_reg(condition_flags_reg),
	.irq_accept(irq_accept), .wdog_up_counter(wdog_up_counter), .wdog_restart_flag(wdog_restart_flag));

// [testbench/rxs_sequencer_tb.sv]
// Bench for the sequencer, with the pin model and a vector memory.
// Assumes inputs change at falling edges.
`timescale 1ns/10ps
module rxs_sequencer_tb;
	reg         clock = 1'b0, nrst = 1'b0, start = 1'b0, run = 1'b0, tick = 1'b0;
	reg         ack = 1'b0, mclr = 1'b0, done = 1'b0, irq = 1'b0, sh;
	reg  [7:0]  len = 8'h00, rdata = 8'h00;
	reg  [15:0] vec = 16'h5a3c;
	reg  [24:0] rows [0:2];
	wire        pin_n, mem_rd, halt, pc_load, acc, wflag, short, pinit;
	wire [15:0] addr, pcv;
	wire [7:0]  flags, wcnt;
	integer     err_count = 0, checks_done = 0, cyc = 0, loads = 0, l0, i, r;
	always #12.5 clock = !clock;
	rxs_pin_driver drv (.clock(clock), .start(start), .low_len(len), .pin_n(pin_n));
	rxs_sequencer uut (.clock(clock), .nrst(nrst), .chip_init_pin_n(pin_n), .wdog_run_bit(run),
		.wdog_tick(tick), .mem_addr(addr), .mem_rd(mem_rd), .mem_ack(ack), .mem_rdata(rdata),
		.core_halt(halt), .periph_init(pinit), .pc_load_value(pcv), .pc_load(pc_load), .condition_flags_reg(flags),
		.mask_flag_clear(mclr), .insn_done(done), .irq_req(irq), .irq_accept(acc), .wdog_up_counter(wcnt),
		.wdog_restart_flag(wflag), .low_time_short(short));
	always @(negedge clock) begin
		ack <= mem_rd;
		rdata <= addr[0] ? vec[7:0] : vec[15:8];
	end
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (pc_load) loads <= loads + 1;
		if (cyc == 20000) begin
			err_count = err_count + 1;
			end_sim;
		end
	end
	task chk(input [15:0] seen, input [15:0] exp);
		begin
			checks_done = checks_done + 1;
			if (seen !== exp) begin
				err_count = err_count + 1;
				$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
			end
		end
	endtask
	task end_sim;
		begin
			$display("errors %0d checks %0d", err_count, checks_done);
			if (err_count == 0 && checks_done > 0) $display("Result: passed");
			else $display("Result: failed");
			$finish;
		end
	endtask
	task wait_load(input integer n);
		for (i = 0; i < n && loads == l0; i = i + 1) @(negedge clock);
	endtask
	task ticks(input integer n);
		begin
			tick <= 1'b1;
			repeat (n) @(negedge clock);
			tick <= 1'b0;
			repeat (3) @(negedge clock);
		end
	endtask
	initial begin
		rows[0] = {8'd18, 16'h1234, 1'b0};
		rows[1] = {8'd17, 16'h0f0f, 1'b1};
		rows[2] = {8'd40, 16'hbeef, 1'b0};
		repeat (2) @(negedge clock);
		chk(halt, 1'b1);
		chk(flags, 8'h80);
		chk(pc_load, 1'b0);
		chk(pinit, 1'b1);
		nrst <= 1'b1;
		l0 = 0;
		wait_load(100);
		chk(pcv, vec);
		chk(pinit, 1'b0);
		for (r = 0; r < 3; r = r + 1) begin
			{len, vec, sh} = rows[r];
			l0 = loads;
			start <= 1'b1;
			@(negedge clock);
			start <= 1'b0;
			wait_load(len + 60);
			chk(short, sh);
			chk(halt, sh);
			if (!sh) chk(pcv, vec);
		end
		chk(flags[7], 1'b1);
		irq <= 1'b1;
		done <= 1'b1;
		#2 chk(acc, 1'b0);
		@(negedge clock);
		mclr <= 1'b1;
		#2 chk(acc, 1'b0);
		@(negedge clock);
		mclr <= 1'b0;
		#2 chk(acc, 1'b1);
		@(negedge clock);
		done <= 1'b0;
		#2 chk(acc, 1'b0);
		@(negedge clock);
		irq <= 1'b0;
		run <= 1'b1;
		ticks(16);
		chk(wcnt, 8'h10);
		ticks(240);
		chk(wflag, 1'b1);
		chk(halt, 1'b1);
		l0 = loads;
		ticks(256);
		wait_load(60);
		chk(loads[15:0] - l0[15:0], 16'h0001);
		chk(pcv, vec);
		nrst <= 1'b0;
		@(negedge clock);
		chk(halt, 1'b1);
		chk(wflag, 1'b0);
		chk(wcnt, 8'h00);
		nrst <= 1'b1;
		l0 = loads;
		wait_load(60);
		chk(loads[15:0] - l0[15:0], 16'h0001);
		chk(pcv, vec);
		end_sim;
	end
endmodule // rxs_sequencer_tb
